// file: shared/psm_pkg.sv
// Constants, register map, field layout and carrier types for the pixel sampling code mapper.
// Assumes one 100 MHz clock domain; analogue levels arrive already digitised in microvolts.
package psm_pkg;

   // Width of a signed voltage word, in microvolts.
   localparam int VOLT_W = 24;
   localparam int CODE_W = 16;

   // Register byte offsets on the AHB-Lite port.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CYCLE_RESET = 8'h04;
   localparam logic [7:0] ADDR_OFFSET_BASE = 8'h08;
   localparam logic [7:0] ADDR_GAIN_BASE = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_STEP = 8'h04;

   // Control register field positions.
   localparam int CTL_DUAL_SAMPLE = 0;
   localparam int CTL_COMPAT_TIMING = 1;
   localparam int CTL_LOW_REF = 2;
   localparam int CTL_INVERT = 3;
   localparam int CTL_REF_PD = 4;
   localparam int CTL_RANGE_LO = 5;
   localparam int CTL_RSPOS_LO = 7;
   localparam int CTL_LINE_BY_LINE = 9;
   localparam int CTL_AUTO_CYCLE = 10;
   localparam int CTL_INTERVAL_LO = 11;
   localparam int CTL_CHANNEL_LO = 13;
   localparam int CTL_REFCODE_LO = 15;
   localparam int CTL_W = 19;

   // Reset values.
   localparam logic [CTL_W-1:0] CTRL_RESET = 19'h00001;
   localparam logic [7:0] OFFSET_RESET = 8'h80;
   localparam logic [8:0] GAIN_RESET = 9'h000;

   // Offset stage: 260 mV * (code - 127.5) / 127.5, kept in integers as doubled terms.
   localparam int OFS_SPAN_UV = 260000;
   localparam int OFS_DOUBLE_MID = 255;

   // Gain stage: 0.66 + code * 7.34 / 511, scaled by 100 * 511.
   localparam int GAIN_BASE = 33726;
   localparam int GAIN_STEP = 734;
   localparam int GAIN_DEN = 51100;

   // Converter scaling and black-level placement.
   localparam int CODE_FS = 65535;
   localparam int VFS_HIGH_UV = 2000000;
   localparam int VFS_LOW_UV = 1200000;
   localparam int BIAS_BIPOLAR = 32767;
   localparam int BIAS_TOP = 65535;

   // Internal reference generator defaults.
   localparam int REF_STEP_UV = 100000;
   localparam int REF_MIN_UV = 400000;

   typedef enum logic [1:0] {
      RANGE_BIPOLAR_A = 2'b00,
      RANGE_BIPOLAR_B = 2'b01,
      RANGE_TOP = 2'b10,
      RANGE_BOTTOM = 2'b11
   } psm_range_t;

   typedef enum logic [1:0] {
      SET_RED = 2'b00,
      SET_GREEN = 2'b01,
      SET_BLUE = 2'b10
   } psm_set_t;

   typedef struct packed {
      logic signed [VOLT_W-1:0] video_uv;
      logic signed [VOLT_W-1:0] reference_pin_uv;
   } psm_analog_t;

   typedef struct packed {
      logic video_sample_strobe;
      logic reset_sample_strobe;
      logic master_clock;
   } psm_strobe_t;

   typedef struct packed {
      logic valid;
      logic [CODE_W-1:0] code;
   } psm_code_t;

endpackage

// file: logic/psm_mapper.sv
// Pixel sampling code mapper: sample timing, offset and gain path, code placement and inversion.
// Assumes strobes and master clock are synchronous to clk, one AHB-Lite master, levels in microvolts.
//
// Contract
// R01: Normal timing captures the video level when the video strobe falls.
// R02: Normal timing with dual sampling captures the reset level when the reset strobe falls.
// R03: Dual-sample enable bit chooses correlated or single-ended sampling, resets to one.
// R04: Single-ended sampling takes the reference level together with the video sample.
// R05: Compatible timing samples video at first master-clock rise after strobe falls.
// R06: Compatible timing, single-ended, takes the reference on that same master-clock rise.
// R07: Compatible timing, dual sampling, reset position field places the reset sample.
// R08: Each colour keeps its own 8-bit offset and 9-bit gain code.
// R09: Line-by-line mode steps colour sets on reset strobe pulses or uses interval select.
// R10: Offset adds 260 mV times (code minus 127.5) over 127.5.
// R11: Gain multiplies by 0.66 plus gain code times 7.34 over 511.
// R12: Dual sampling subtracts the earlier reset level from the video level.
// R13: Reference comes from the pin when generator is off, else step times code plus minimum.
// R14: Code is integer part of output over full scale times 65535 plus range bias.
// R15: Range field 10 adds 65535, so zero input gives FFFF.
// R16: Range field 11 adds nothing, so zero input gives 0000.
// R17: Range field 00 or 01 adds 32767, so zero input gives 7FFF.
// R18: Full scale is 2 V with low reference clear and 1.2 V when set.
// R19: Output invert returns 65535 minus the code, otherwise passes it unchanged.
// R20: Software sets gain first, then offset, then the reference generator code.
// R21: In compatible timing the master clock runs at twice the conversion rate.
// R22: The code saturates to 0..65535 before inversion.
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps

module psm_mapper
   import psm_pkg::*;
#(
   parameter int REF_STEP = psm_pkg::REF_STEP_UV,
   parameter int REF_MIN = psm_pkg::REF_MIN_UV
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire psm_pkg::psm_strobe_t strobe,
   input wire psm_pkg::psm_analog_t analog,
   output psm_pkg::psm_code_t pixel_out
);
   import psm_pkg::*;

   if (REF_STEP < 0 || REF_STEP > 500000 || REF_MIN < -4000000 || REF_MIN > 4000000) begin : g_bad_ref
      $error("Reference generator step or minimum out of range.");
   end

   localparam logic signed [63:0] DEN_HIGH = 64'(GAIN_DEN) * 64'(VFS_HIGH_UV);
   localparam logic signed [63:0] DEN_LOW = 64'(GAIN_DEN) * 64'(VFS_LOW_UV);

   typedef struct packed {
      logic [CTL_W-1:0] ctrl;
      logic [2:0][7:0] offset_code;
      logic [2:0][8:0] gain_code;
      logic [1:0] cycle_set;
      logic video_prev;
      logic reset_prev;
      logic mclk_prev;
      logic compat_armed;
      logic reset_wait;
      logic [1:0] reset_count;
      logic signed [VOLT_W-1:0] reset_level;
      logic p0_valid;
      logic signed [VOLT_W-1:0] p0_video;
      logic signed [VOLT_W-1:0] p0_ref;
      logic p1_valid;
      logic signed [31:0] p1_v2;
      logic [19:0] p1_gain;
      logic p2_valid;
      logic signed [63:0] p2_scaled;
      logic out_valid;
      logic [CODE_W-1:0] out_code;
      logic saturated;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
   } psm_state_t;

   psm_state_t s_q;
   psm_state_t s_d;
   logic [1:0] rst_sync_q;
   logic rst_n;

   // The release is synchronised so that every state flop leaves reset on the same edge.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Colour set that feeds the offset and gain path.
   function automatic logic [1:0] active_set(input psm_state_t s);
      logic [1:0] sel;
      sel = s.ctrl[CTL_CHANNEL_LO +: 2];
      if (s.ctrl[CTL_LINE_BY_LINE]) begin
         if (s.ctrl[CTL_AUTO_CYCLE]) begin
            sel = s.cycle_set; // [R09]
         end else begin
            sel = s.ctrl[CTL_INTERVAL_LO +: 2]; // [R09]
         end
      end
      if (sel == 2'h3) begin
         sel = SET_RED;
      end
      return sel;
   endfunction

   // Index of an offset or gain register, or 3 when the address is not one.
   function automatic logic [1:0] coef_index(input logic [7:0] addr, input logic [7:0] base);
      logic [7:0] rel;
      rel = addr - base;
      if (rel == 8'h00) begin
         return 2'h0;
      end else if (rel == ADDR_STEP) begin
         return 2'h1;
      end else if (rel == 8'h08) begin
         return 2'h2;
      end
      return 2'h3;
   endfunction

   function automatic logic [31:0] read_word(input psm_state_t s, input logic [7:0] addr);
      logic [1:0] oi;
      logic [1:0] gi;
      oi = coef_index(addr, ADDR_OFFSET_BASE);
      gi = coef_index(addr, ADDR_GAIN_BASE);
      if (addr == ADDR_CTRL) begin
         return {13'h0000, s.ctrl};
      end else if (addr == ADDR_STATUS) begin
         return {13'h0000, s.saturated, active_set(s), s.out_code};
      end else if (oi != 2'h3) begin
         return {24'h000000, s.offset_code[oi]};
      end else if (gi != 2'h3) begin
         return {23'h000000, s.gain_code[gi]};
      end
      return 32'h00000000;
   endfunction

   // Single-ended reference level.
   function automatic logic signed [VOLT_W-1:0] ref_level(input psm_state_t s, input psm_analog_t a);
      logic signed [31:0] gen;
      gen = 32'(REF_STEP) * $signed({28'h0000000, s.ctrl[CTL_REFCODE_LO +: 4]}) + 32'(REF_MIN);
      if (s.ctrl[CTL_REF_PD]) begin
         return a.reference_pin_uv; // [R13]
      end
      return gen[VOLT_W-1:0]; // [R13]
   endfunction

   logic video_fall;
   logic reset_fall;
   logic mclk_rise;
   logic capture;
   logic bus_take;
   logic [1:0] sel;
   logic [1:0] wi;
   logic signed [31:0] v1;
   logic signed [31:0] ofs;
   logic signed [63:0] prod;
   logic signed [63:0] biased;
   logic [CODE_W-1:0] code;

   always_comb begin
      s_d = s_q;
      video_fall = s_q.video_prev & ~strobe.video_sample_strobe;
      reset_fall = s_q.reset_prev & ~strobe.reset_sample_strobe;
      mclk_rise = ~s_q.mclk_prev & strobe.master_clock;
      capture = 1'b0;
      s_d.video_prev = strobe.video_sample_strobe;
      s_d.reset_prev = strobe.reset_sample_strobe;
      s_d.mclk_prev = strobe.master_clock;

      // Sampling instants.
      if (!s_q.ctrl[CTL_COMPAT_TIMING]) begin
         s_d.compat_armed = 1'b0;
         s_d.reset_wait = 1'b0;
         capture = video_fall; // [R01]
         if (reset_fall && s_q.ctrl[CTL_DUAL_SAMPLE]) begin
            s_d.reset_level = analog.video_uv; // [R02] [R03]
         end
      end else begin
         // The master clock pace is left to the timing controller.
         if (video_fall) begin
            s_d.compat_armed = 1'b1;
         end
         if ((s_q.compat_armed || video_fall) && mclk_rise) begin
            capture = 1'b1; // [R05] [R21]
            s_d.compat_armed = 1'b0;
            s_d.reset_count = 2'h0;
            s_d.reset_wait = s_q.ctrl[CTL_DUAL_SAMPLE];
         end else if (s_q.reset_wait && mclk_rise) begin
            if (s_q.reset_count == s_q.ctrl[CTL_RSPOS_LO +: 2]) begin
               s_d.reset_level = analog.video_uv; // [R07]
               s_d.reset_wait = 1'b0;
            end else begin
               s_d.reset_count = s_q.reset_count + 2'h1; // [R07]
            end
         end
      end

      // The reference is frozen together with the video level; in compat timing this is the
      // same master-clock edge.
      s_d.p0_valid = capture;
      if (capture) begin
         s_d.p0_video = analog.video_uv; // [R01]
         if (s_q.ctrl[CTL_DUAL_SAMPLE]) begin
            s_d.p0_ref = s_q.reset_level; // [R12]
         end else begin
            s_d.p0_ref = ref_level(s_q, analog); // [R04] [R06]
         end
      end

      // Auto-cycle stepping on each reset strobe pulse.
      if (s_q.ctrl[CTL_LINE_BY_LINE] && s_q.ctrl[CTL_AUTO_CYCLE] && reset_fall) begin
         s_d.cycle_set = (s_q.cycle_set == SET_BLUE) ? SET_RED : s_q.cycle_set + 2'h1; // [R09]
      end

      // Stage 1: difference, offset and gain numerator.
      sel = active_set(s_q);
      v1 = 32'(s_q.p0_video) - 32'(s_q.p0_ref); // [R12]
      ofs = (32'(OFS_SPAN_UV) * ($signed({24'h000000, s_q.offset_code[sel]}) * 32'sd2
            - 32'(OFS_DOUBLE_MID))) / 32'(OFS_DOUBLE_MID); // [R10]
      s_d.p1_valid = s_q.p0_valid;
      s_d.p1_v2 = v1 + ofs; // [R10]
      s_d.p1_gain = 20'(GAIN_BASE) + 20'(GAIN_STEP) * {11'h000, s_q.gain_code[sel]}; // [R08] [R11]

      // Stage 2: gain and scaling to code units, truncated toward zero.
      prod = 64'(s_q.p1_v2) * $signed({44'h00000000000, s_q.p1_gain}) * 64'(CODE_FS); // [R11] [R14]
      s_d.p2_valid = s_q.p1_valid;
      if (s_q.ctrl[CTL_LOW_REF]) begin
         s_d.p2_scaled = prod / DEN_LOW; // [R18]
      end else begin
         s_d.p2_scaled = prod / DEN_HIGH; // [R18]
      end

      // Stage 3: black-level placement, clamp, inversion.
      case (psm_range_t'(s_q.ctrl[CTL_RANGE_LO +: 2]))
         RANGE_TOP: begin
            biased = s_q.p2_scaled + 64'(BIAS_TOP); // [R15]
         end
         RANGE_BOTTOM: begin
            biased = s_q.p2_scaled; // [R16]
         end
         default: begin
            biased = s_q.p2_scaled + 64'(BIAS_BIPOLAR); // [R17]
         end
      endcase
      if (biased < 64'sd0) begin
         code = 16'h0000; // [R22]
      end else if (biased > 64'(CODE_FS)) begin
         code = 16'hFFFF; // [R22]
      end else begin
         code = biased[CODE_W-1:0]; // [R14]
      end
      s_d.out_valid = s_q.p2_valid;
      if (s_q.p2_valid) begin
         s_d.saturated = (biased < 64'sd0) || (biased > 64'(CODE_FS));
         s_d.out_code = s_q.ctrl[CTL_INVERT] ? 16'(CODE_FS) - code : code; // [R19]
      end

      // Bus write data phase; each coefficient register stands alone.
      wi = coef_index(s_q.wr_addr, ADDR_OFFSET_BASE);
      if (s_q.wr_pend) begin
         if (s_q.wr_addr == ADDR_CTRL) begin
            s_d.ctrl = hwdata[CTL_W-1:0]; // [R03]
         end else if (s_q.wr_addr == ADDR_CYCLE_RESET) begin
            s_d.cycle_set = SET_RED; // [R09]
         end else if (wi != 2'h3) begin
            s_d.offset_code[wi] = hwdata[7:0]; // [R08]
         end else if (coef_index(s_q.wr_addr, ADDR_GAIN_BASE) != 2'h3) begin
            s_d.gain_code[coef_index(s_q.wr_addr, ADDR_GAIN_BASE)] = hwdata[8:0]; // [R08]
         end
      end

      // Bus address phase; read data is taken from the state already holding any pending write.
      bus_take = hsel && htrans[1] && hready;
      s_d.wr_pend = bus_take && hwrite;
      s_d.wr_addr = haddr[7:0];
      if (bus_take && !hwrite) begin
         s_d.rdata = (haddr[31:8] == 24'h000000) ? read_word(s_d, haddr[7:0]) : 32'h00000000;
      end
      if (bus_take && (haddr[31:8] != 24'h000000)) begin
         s_d.wr_pend = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.ctrl <= CTRL_RESET; // [R03]
         s_q.offset_code <= {3{OFFSET_RESET}};
         s_q.gain_code <= {3{GAIN_RESET}};
      end else begin
         s_q <= s_d;
      end
   end

   // Zero-wait slave; a read returns the word registered at its address phase.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign pixel_out.valid = s_q.out_valid;
   assign pixel_out.code = s_q.out_code;

endmodule // psm_mapper

// file: verification/psm_mapper_asserts.sv
// Port checker for the pixel sampling code mapper.
// Assumes it is bound to psm_mapper and sees only that module's ports.
`timescale 1ns/1ps
module psm_mapper_asserts (
   input wire logic clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire psm_pkg::psm_strobe_t strobe,
   input wire psm_pkg::psm_analog_t analog,
   input wire psm_pkg::psm_code_t pixel_out
);
   import psm_pkg::*;
   logic wr_ctrl_q, vs_q, mc_q;
   logic [CTL_W-1:0] ctrl_q;
   logic [3:0] since_q;
   wire logic take = hsel && htrans[1] && hready;
   wire logic bad_addr = haddr[31:8] != 24'h0 || haddr[1:0] != 2'h0 || haddr[7:0] > ADDR_STATUS
      || haddr[7:0] == ADDR_CYCLE_RESET;
   wire logic capture = (vs_q && !strobe.video_sample_strobe) || (!mc_q && strobe.master_clock);
   // A shadow of the control word lets mode-dependent timing be judged from the ports alone.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_ctrl_q <= 1'b0;
         vs_q <= 1'b0;
         mc_q <= 1'b0;
         ctrl_q <= CTRL_RESET;
         since_q <= 4'hF;
      end else begin
         wr_ctrl_q <= take && hwrite && haddr == 32'h0;
         vs_q <= strobe.video_sample_strobe;
         mc_q <= strobe.master_clock;
         if (wr_ctrl_q) ctrl_q <= hwdata[CTL_W-1:0];
         if (capture) since_q <= 4'h0;
         else if (since_q != 4'hF) since_q <= since_q + 4'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   hresp_okay_a: assert property (hresp == 1'b0) else $error("response not OKAY");
   ready_always_a: assert property (hreadyout == 1'b1) else $error("wait state inserted");
   valid_pulse_a: assert property (pixel_out.valid |=> !pixel_out.valid) else $error("valid held too long");
   code_hold_a: assert property (!pixel_out.valid |-> $stable(pixel_out.code)) else $error("code moved alone");
   capture_latency_a: assert property ($fell(strobe.video_sample_strobe) && !ctrl_q[CTL_COMPAT_TIMING]
      |-> ##[3:5] pixel_out.valid) else $error("no code after video strobe fall");
   valid_cause_a: assert property (pixel_out.valid |-> since_q inside {[4'h1:4'h5]})
      else $error("code without a capture");
   unmapped_zero_a: assert property (take && !hwrite && bad_addr |=> hrdata == 32'h0) else $error("unmapped read");
   ctrl_readback_a: assert property (take && !hwrite && haddr == 32'h0 |=> hrdata == {13'h0, ctrl_q})
      else $error("control readback wrong");
   reset_quiet_a: assert property (disable iff (1'b0) !resetn |-> !pixel_out.valid && pixel_out.code == 16'h0)
      else $error("output active in reset");
   valid_seen_c: cover property (pixel_out.valid);
   compat_rise_c: cover property (ctrl_q[CTL_COMPAT_TIMING] && capture);
   ctrl_read_c: cover property (take && !hwrite && haddr == 32'h0);
   compat_dual_c: cover property (ctrl_q[CTL_COMPAT_TIMING] && ctrl_q[CTL_DUAL_SAMPLE] && pixel_out.valid);
endmodule // psm_mapper_asserts

bind psm_mapper psm_mapper_asserts psm_mapper_asserts_i (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
   .hwdata, .hready, .hreadyout, .hresp, .hrdata, .strobe, .analog, .pixel_out);

// file: verification/psm_sensor_model.sv
// Sensor and timing controller model: strobes, master clock and analogue levels.
// Assumes clk is the mapper clock; every change lands just after a rising edge.
`timescale 1ns/1ps
module psm_sensor_model (
   input wire logic clk,
   output psm_pkg::psm_strobe_t strobe,
   output psm_pkg::psm_analog_t analog
);
   import psm_pkg::*;
   initial begin
      strobe = '0;
      analog = '0;
   end
   // Levels are inverted once their hold ends, so a late sample never sees a good value.
   task automatic hold_then_drop(input int n);
      repeat (n) @(posedge clk);
      analog <= ~analog;
   endtask
   task automatic pulse_reset(input int lvl);
      analog.video_uv <= VOLT_W'(lvl);
      strobe.reset_sample_strobe <= 1'b1;
      repeat (2) @(posedge clk);
      strobe.reset_sample_strobe <= 1'b0;
      hold_then_drop(2);
      @(posedge clk);
   endtask
   task automatic pixel(input int vid, rf, rs, input logic dual, compat);
      int i;
      if (dual) pulse_reset(rs);
      strobe.video_sample_strobe <= 1'b1;
      analog <= {VOLT_W'(vid), VOLT_W'(rf)};
      repeat (2) @(posedge clk);
      strobe.video_sample_strobe <= 1'b0;
      if (compat) begin
         analog <= ~{VOLT_W'(vid), VOLT_W'(rf)};
         repeat (3) @(posedge clk);
         for (i = 0; i < 2; i++) begin // two master-clock periods per pixel
            strobe.master_clock <= 1'b1;
            if (i == 0) analog <= {VOLT_W'(vid), VOLT_W'(rf)};
            repeat (2) @(posedge clk);
            strobe.master_clock <= 1'b0;
            repeat (2) @(posedge clk);
         end
      end
      hold_then_drop(2);
   endtask
endmodule // psm_sensor_model

// file: verification/test_pixel_sampling_code_mapper.sv
// Self-checking bench for the pixel sampling code mapper.
// Assumes the sensor model and the mapper; this module is the AHB-Lite master.
`timescale 1ns/1ps
module test_pixel_sampling_code_mapper;
   import psm_pkg::*;
   logic clk = 1'b0;
   logic resetn;
   logic hsel = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp;
   logic [31:0] hrdata;
   psm_strobe_t strobe;
   psm_analog_t analog;
   psm_code_t pixel_out;
   logic [CTL_W-1:0] cur;
   int n_mismatch = 0;
   int samples_checked = 0;
   int ofs_r[3] = '{128, 192, 0};
   int gn_r[3] = '{0, 255, 511};
   psm_mapper psm_mapper_i (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .strobe, .analog, .pixel_out);
   psm_sensor_model psm_sensor_model_i (.clk, .strobe, .analog);
   always #5 clk = ~clk;
   task automatic check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, wd, output logic [31:0] rd);
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rdchk(input logic [31:0] a, exp, input string what);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      check(what, v, exp);
   endtask
   function automatic logic [31:0] ra(input logic [7:0] base, input int i);
      return {24'h0, base + 8'(4 * i)};
   endfunction
   function automatic logic [15:0] want(input longint v1, input int ch);
      longint o, d;
      o = 64'sd260000 * (2 * ofs_r[ch] - 255) / 255;
      d = (v1 + o) * (GAIN_BASE + GAIN_STEP * gn_r[ch]) * 65535 / (64'sd51100 * (cur[CTL_LOW_REF] ? 1200000 : 2000000));
      d += cur[CTL_RANGE_LO +: 2] == 2'h2 ? 65535 : cur[CTL_RANGE_LO +: 2] == 2'h3 ? 0 : 32767;
      d = d < 0 ? 0 : d > 65535 ? 65535 : d;
      return cur[CTL_INVERT] ? 16'(65535 - d) : 16'(d);
   endfunction
   task automatic px(input int vid, rf, rs, v1, ch);
      int k;
      wr(ra(ADDR_CTRL, 0), 32'(cur));
      fork
         psm_sensor_model_i.pixel(vid, rf, rs, cur[CTL_DUAL_SAMPLE], cur[CTL_COMPAT_TIMING]);
         for (k = 0; k < 60 && pixel_out.valid !== 1'b1; k++) @(posedge clk);
      join
      check("pixel valid", 32'(k < 60), 32'h1);
      check("pixel code", {16'h0, pixel_out.code}, {16'h0, want(v1, ch)});
   endtask
   task automatic setchk(input int e);
      logic [31:0] v;
      bus(1'b0, ra(ADDR_STATUS, 0), 32'h0, v);
      check("active set", {30'h0, v[17:16]}, 32'(e));
   endtask
   task automatic t_regs();
      rdchk(ra(ADDR_CTRL, 0), 32'h1, "control");
      for (int i = 0; i < 3; i++) begin
         rdchk(ra(ADDR_OFFSET_BASE, i), 32'h80, "offset");
         rdchk(ra(ADDR_GAIN_BASE, i), 32'h0, "gain");
      end
      for (int i = 0; i < 3; i++) wr(ra(ADDR_GAIN_BASE, i), 32'(gn_r[i]));
      for (int i = 0; i < 3; i++) wr(ra(ADDR_OFFSET_BASE, i), 32'(ofs_r[i]));
      for (int i = 0; i < 3; i++) begin
         rdchk(ra(ADDR_OFFSET_BASE, i), 32'(ofs_r[i]), "offset");
         rdchk(ra(ADDR_GAIN_BASE, i), 32'(gn_r[i]), "gain");
      end
      rdchk(32'h24, 32'h0, "unmapped");
      rdchk(32'h100, 32'h0, "high address");
      rdchk(ra(ADDR_CYCLE_RESET, 0), 32'h0, "cycle reset");
      $display("registers done");
   endtask
   task automatic t_range();
      logic [CTL_W-1:0] tc[4] = '{19'h74, 19'h50, 19'h58, 19'h70};
      int dv[4] = '{500000, 300000, 300000, -300000};
      for (int r = 0; r < 8; r++) begin
         cur = CTL_W'(32'h10 | ((r % 4) << CTL_RANGE_LO) | ((r / 4) << CTL_INVERT));
         px(600000, 600000, 0, 0, 0);
      end
      for (int t = 0; t < 4; t++) begin
         cur = tc[t];
         px(600000 + dv[t], 600000, 0, dv[t], 0);
      end
      $display("ranges done");
   endtask
   task automatic t_paths();
      cur = 19'h02001;
      px(600000, 0, 700000, -100000, 1);
      cur = 19'h04001;
      px(1050000, 0, 700000, 350000, 2);
      cur = 19'h28000;
      px(1000000, 0, 0, 1000000 - (REF_STEP_UV * 5 + REF_MIN_UV), 0);
      cur = 19'h00012;
      px(800000, 600000, 0, 200000, 0);
      // The first pixel still uses the earlier 700 mV reset level, the second the one taken after the first.
      cur = 19'h00003;
      px(500000, 0, 0, 500000 - 700000, 0);
      px(900000, 0, 0, 900000 - 500000, 0);
      $display("sampling paths done");
   endtask
   task automatic t_cycle();
      cur = 19'h00600;
      wr(ra(ADDR_CTRL, 0), 32'(cur));
      wr(ra(ADDR_CYCLE_RESET, 0), 32'h0);
      for (int i = 1; i < 5; i++) begin
         psm_sensor_model_i.pulse_reset(0);
         setchk(i % 3);
      end
      wr(ra(ADDR_CYCLE_RESET, 0), 32'h0);
      setchk(0);
      for (int m = 0; m < 3; m++) begin
         wr(ra(ADDR_CTRL, 0), 32'h200 | (32'(m) << CTL_INTERVAL_LO));
         setchk(m);
      end
      $display("colour cycling done");
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      $display("watchdog expired");
      give_verdict();
   end
   initial begin
      // A non-blocking drive at time zero makes sure the asynchronous resets see their falling edge.
      resetn <= 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs();
      t_range();
      t_paths();
      t_cycle();
      give_verdict();
   end
endmodule // test_pixel_sampling_code_mapper
